// [hw/irq_bank_consts.vh]
// register offsets, field positions and reset values of the interrupt enable/flag bank
`ifndef IRQ_BANK_CONSTS_VH
`define IRQ_BANK_CONSTS_VH

`define ADDR_W 12
`define PIN_FLAG_W 24

`define OFS_ENABLE3 12'h000
`define OFS_ENABLE4 12'h004
`define OFS_FLAG0 12'h008
`define OFS_FLAG1 12'h00C

`define RST_ENABLE3 8'h00
`define RST_ENABLE4 8'h00
`define RST_FLAG0 8'h00
`define RST_FLAG1 8'h00

// enable register three
`define BIT_OSC_FAIL_EN 7
`define BIT_CLK_SWITCH_EN 6
`define BIT_TIMER3_GATE_EN 5
`define BIT_TIMER3_OVF_EN 4
`define BIT_LOGIC_CELL4_EN 3
`define BIT_LOGIC_CELL3_EN 2
`define BIT_LOGIC_CELL2_EN 1
`define BIT_LOGIC_CELL1_EN 0
// enable register four
`define BIT_WAVEGEN2_EN 7
`define BIT_WAVEGEN1_EN 6
`define BIT_TIMER5_GATE_EN 5
`define BIT_TIMER5_OVF_EN 4
`define BIT_CAPCOMP4_EN 3
`define BIT_CAPCOMP3_EN 2
`define BIT_CAPCOMP2_EN 1
`define BIT_CAPCOMP1_EN 0

// flag register zero
`define BIT_TIMER0_OVF 5
`define BIT_PIN_CHANGE 4
`define BIT_EXT_PIN 0
// writable and implemented bits of flag register zero
`define FLAG0_WMASK 8'h21
// flag register one
`define BIT_TIMER1_GATE 7
`define BIT_CONV_DONE 6
`define BIT_UART_RX 5
`define BIT_UART_TX 4
`define BIT_SERIAL_EVT 3
`define BIT_BUS_COLL 2
`define BIT_TIMER2_MATCH 1
`define BIT_TIMER1_OVF 0
// hardware-set, software-writable bits of flag register one
`define FLAG1_WMASK 8'hCF

`endif

// [hw/peripheral_irq_enable_flags.v]
// peripheral interrupt enable and request flag registers behind an APB slave
// Summary of operation
// - enable3 bit 7 gates oscillator failure
// - enable3 bit 6 gates clock switch done
// - enable3 bits 5/4 gate timer3 gate/overflow
// - enable3 bits 3..0 gate logic cells 4..1
// - enable4 bits 7/6 gate wavegens 2/1
// - enable4 bits 5/4 gate timer5 gate/overflow
// - enable4 bits 3..0 gate capcomp 4..1
// - enable bits read/write, reset to zero
// - flag0 bits 7-6, 3-1 read zero
// - flag0 bit 5 sticky timer0 overflow
// - flag0 bit 4 ORs pin change flags
// - flag0 bit 0 sticky external pin event
// - flag1 bit 7 set on timer1 gate close
// - flag1 bit 6 set on conversion done
// - flag1 bit 5 live uart rx nonempty
// - flag1 bit 4 live uart tx empty
// - flag1 bit 3 sticky serial port event
// - flag1 bit 2 sticky bus collision
// - flag1 bit 1 sticky timer2 period match
// - flag1 bit 0 sticky timer1 overflow
// - hardware-set flags writable, reset to zero
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "irq_bank_consts.vh"

module peripheral_irq_enable_flags
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire timer0_ovf_evt,
	input wire ext_pin_evt,
	input wire [`PIN_FLAG_W-1:0] per_pin_change_flags,
	input wire timer1_gate_closed_evt,
	input wire conversion_done_evt,
	input wire uart_rx_nonempty,
	input wire uart_tx_empty,
	input wire serial_port_evt,
	input wire bus_collision_evt,
	input wire timer2_match_evt,
	input wire timer1_ovf_evt,
	input wire [7:0] irq_enable_reg0,
	input wire [7:0] irq_enable_reg1,
	input wire [7:0] irq_flag_reg3,
	input wire [7:0] irq_flag_reg4,
	output wire [7:0] enable3_out,
	output wire [7:0] enable4_out,
	output wire [7:0] flag0_out,
	output wire [7:0] flag1_out,
	output reg periph_irq_req
);

	reg [7:0] irq_enable_reg3;
	reg [7:0] irq_enable_reg4;
	wire [7:0] irq_flag_reg0;
	wire [7:0] irq_flag_reg1;

	localparam [7:0] flag0_reset = `RST_FLAG0;
	localparam [7:0] flag1_reset = `RST_FLAG1;

	// sticky request flags, one per hardware-set source
	wire timer0_ovf_flag;
	wire ext_pin_irq_flag;
	wire timer1_gate_flag;
	wire conversion_done_flag;
	wire serial_port_event_flag;
	wire bus_collision_flag;
	wire timer2_match_flag;
	wire timer1_ovf_flag;

	// live status bits, never stored here
	wire pin_change_summary_flag;
	wire uart_rx_nonempty_flag;
	wire uart_tx_empty_flag;

	wire wr_flag0;
	wire wr_flag1;

	// named enable bits
	wire osc_fail_irq_en;
	wire clk_switch_done_irq_en;
	wire timer3_gate_irq_en;
	wire timer3_ovf_irq_en;
	wire logic_cell4_irq_en;
	wire logic_cell3_irq_en;
	wire logic_cell2_irq_en;
	wire logic_cell1_irq_en;
	wire wavegen2_irq_en;
	wire wavegen1_irq_en;
	wire timer5_gate_irq_en;
	wire timer5_ovf_irq_en;
	wire capcomp4_irq_en;
	wire capcomp3_irq_en;
	wire capcomp2_irq_en;
	wire capcomp1_irq_en;
	wire setup_phase;
	wire wr_en;
	wire lane0;
	wire mapped;
	wire next_req;
	reg [7:0] read_byte;

	assign setup_phase = psel & ~penable;
	assign wr_en = psel & penable & pwrite & mapped;
	// only the low lane holds data; other lanes are ignored
	assign lane0 = pstrb[0];
	assign mapped = (paddr == `OFS_ENABLE3) | (paddr == `OFS_ENABLE4) |
		(paddr == `OFS_FLAG0) | (paddr == `OFS_FLAG1);
	// zero wait states: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_enable_reg3 <= `RST_ENABLE3;
			irq_enable_reg4 <= `RST_ENABLE4;
		end
		else if (wr_en && lane0)
		begin
			if (paddr == `OFS_ENABLE3)
				irq_enable_reg3 <= pwdata[7:0];
			if (paddr == `OFS_ENABLE4)
				irq_enable_reg4 <= pwdata[7:0];
		end
	end

	// pulses from the peripherals; a level held high keeps the flag set
	assign wr_flag0 = wr_en & lane0 & (paddr == `OFS_FLAG0);
	assign wr_flag1 = wr_en & lane0 & (paddr == `OFS_FLAG1);

	hw_set_flag
	#(
		.RESET_VALUE(flag0_reset[`BIT_TIMER0_OVF])
	)
	i_timer0_ovf_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(timer0_ovf_evt),
		.sw_write(wr_flag0),
		.sw_value(pwdata[`BIT_TIMER0_OVF]),
		.flag(timer0_ovf_flag)
	);

	hw_set_flag
	#(
		.RESET_VALUE(flag0_reset[`BIT_EXT_PIN])
	)
	i_ext_pin_irq_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(ext_pin_evt),
		.sw_write(wr_flag0),
		.sw_value(pwdata[`BIT_EXT_PIN]),
		.flag(ext_pin_irq_flag)
	);

	hw_set_flag
	#(
		.RESET_VALUE(flag1_reset[`BIT_TIMER1_GATE])
	)
	i_timer1_gate_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(timer1_gate_closed_evt),
		.sw_write(wr_flag1),
		.sw_value(pwdata[`BIT_TIMER1_GATE]),
		.flag(timer1_gate_flag)
	);

	hw_set_flag
	#(
		.RESET_VALUE(flag1_reset[`BIT_CONV_DONE])
	)
	i_conversion_done_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(conversion_done_evt),
		.sw_write(wr_flag1),
		.sw_value(pwdata[`BIT_CONV_DONE]),
		.flag(conversion_done_flag)
	);

	hw_set_flag
	#(
		.RESET_VALUE(flag1_reset[`BIT_SERIAL_EVT])
	)
	i_serial_port_event_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(serial_port_evt),
		.sw_write(wr_flag1),
		.sw_value(pwdata[`BIT_SERIAL_EVT]),
		.flag(serial_port_event_flag)
	);

	hw_set_flag
	#(
		.RESET_VALUE(flag1_reset[`BIT_BUS_COLL])
	)
	i_bus_collision_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(bus_collision_evt),
		.sw_write(wr_flag1),
		.sw_value(pwdata[`BIT_BUS_COLL]),
		.flag(bus_collision_flag)
	);

	hw_set_flag
	#(
		.RESET_VALUE(flag1_reset[`BIT_TIMER2_MATCH])
	)
	i_timer2_match_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(timer2_match_evt),
		.sw_write(wr_flag1),
		.sw_value(pwdata[`BIT_TIMER2_MATCH]),
		.flag(timer2_match_flag)
	);

	hw_set_flag
	#(
		.RESET_VALUE(flag1_reset[`BIT_TIMER1_OVF])
	)
	i_timer1_ovf_flag
	(
		.pclk(pclk),
		.presetn(presetn),
		.set_evt(timer1_ovf_evt),
		.sw_write(wr_flag1),
		.sw_value(pwdata[`BIT_TIMER1_OVF]),
		.flag(timer1_ovf_flag)
	);

	// read-only bits follow their sources live and ignore writes
	assign pin_change_summary_flag = |per_pin_change_flags;
	assign uart_rx_nonempty_flag = uart_rx_nonempty;
	assign uart_tx_empty_flag = uart_tx_empty;

	assign irq_flag_reg0 = {
		1'b0,
		1'b0,
		timer0_ovf_flag,
		pin_change_summary_flag,
		1'b0,
		1'b0,
		1'b0,
		ext_pin_irq_flag};
	assign irq_flag_reg1 = {
		timer1_gate_flag,
		conversion_done_flag,
		uart_rx_nonempty_flag,
		uart_tx_empty_flag,
		serial_port_event_flag,
		bus_collision_flag,
		timer2_match_flag,
		timer1_ovf_flag};

	assign enable3_out = irq_enable_reg3;
	assign enable4_out = irq_enable_reg4;
	assign flag0_out = irq_flag_reg0;
	assign flag1_out = irq_flag_reg1;

	always @*
	begin
		case (paddr)
			`OFS_ENABLE3: read_byte = irq_enable_reg3;
			`OFS_ENABLE4: read_byte = irq_enable_reg4;
			`OFS_FLAG0: read_byte = irq_flag_reg0;
			`OFS_FLAG1: read_byte = irq_flag_reg1;
			default: read_byte = 8'h00;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_phase && !pwrite)
			prdata <= {24'h00_0000, read_byte};
	end

	assign osc_fail_irq_en = irq_enable_reg3[`BIT_OSC_FAIL_EN];
	assign clk_switch_done_irq_en = irq_enable_reg3[`BIT_CLK_SWITCH_EN];
	assign timer3_gate_irq_en = irq_enable_reg3[`BIT_TIMER3_GATE_EN];
	assign timer3_ovf_irq_en = irq_enable_reg3[`BIT_TIMER3_OVF_EN];
	assign logic_cell4_irq_en = irq_enable_reg3[`BIT_LOGIC_CELL4_EN];
	assign logic_cell3_irq_en = irq_enable_reg3[`BIT_LOGIC_CELL3_EN];
	assign logic_cell2_irq_en = irq_enable_reg3[`BIT_LOGIC_CELL2_EN];
	assign logic_cell1_irq_en = irq_enable_reg3[`BIT_LOGIC_CELL1_EN];
	assign wavegen2_irq_en = irq_enable_reg4[`BIT_WAVEGEN2_EN];
	assign wavegen1_irq_en = irq_enable_reg4[`BIT_WAVEGEN1_EN];
	assign timer5_gate_irq_en = irq_enable_reg4[`BIT_TIMER5_GATE_EN];
	assign timer5_ovf_irq_en = irq_enable_reg4[`BIT_TIMER5_OVF_EN];
	assign capcomp4_irq_en = irq_enable_reg4[`BIT_CAPCOMP4_EN];
	assign capcomp3_irq_en = irq_enable_reg4[`BIT_CAPCOMP3_EN];
	assign capcomp2_irq_en = irq_enable_reg4[`BIT_CAPCOMP2_EN];
	assign capcomp1_irq_en = irq_enable_reg4[`BIT_CAPCOMP1_EN];

	// pairs with enables 0/1 and flags 3/4 held outside this bank
	assign next_req = |(irq_flag_reg0 & irq_enable_reg0) |
		|(irq_flag_reg1 & irq_enable_reg1) |
		(osc_fail_irq_en & irq_flag_reg3[`BIT_OSC_FAIL_EN]) |
		(clk_switch_done_irq_en & irq_flag_reg3[`BIT_CLK_SWITCH_EN]) |
		(timer3_gate_irq_en & irq_flag_reg3[`BIT_TIMER3_GATE_EN]) |
		(timer3_ovf_irq_en & irq_flag_reg3[`BIT_TIMER3_OVF_EN]) |
		(logic_cell4_irq_en & irq_flag_reg3[`BIT_LOGIC_CELL4_EN]) |
		(logic_cell3_irq_en & irq_flag_reg3[`BIT_LOGIC_CELL3_EN]) |
		(logic_cell2_irq_en & irq_flag_reg3[`BIT_LOGIC_CELL2_EN]) |
		(logic_cell1_irq_en & irq_flag_reg3[`BIT_LOGIC_CELL1_EN]) |
		(wavegen2_irq_en & irq_flag_reg4[`BIT_WAVEGEN2_EN]) |
		(wavegen1_irq_en & irq_flag_reg4[`BIT_WAVEGEN1_EN]) |
		(timer5_gate_irq_en & irq_flag_reg4[`BIT_TIMER5_GATE_EN]) |
		(timer5_ovf_irq_en & irq_flag_reg4[`BIT_TIMER5_OVF_EN]) |
		(capcomp4_irq_en & irq_flag_reg4[`BIT_CAPCOMP4_EN]) |
		(capcomp3_irq_en & irq_flag_reg4[`BIT_CAPCOMP3_EN]) |
		(capcomp2_irq_en & irq_flag_reg4[`BIT_CAPCOMP2_EN]) |
		(capcomp1_irq_en & irq_flag_reg4[`BIT_CAPCOMP1_EN]);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			periph_irq_req <= 1'b0;
		else
			periph_irq_req <= next_req;
	end

endmodule

// one hardware-set, software-writable request flag
module hw_set_flag
#(
	parameter [0:0] RESET_VALUE = 1'b0
)
(
	input wire pclk,
	input wire presetn,
	input wire set_evt,
	input wire sw_write,
	input wire sw_value,
	output reg flag
);

	wire next_flag;

	// set is ORed after the write so an event in a clearing cycle survives
	assign next_flag = set_evt | (sw_write ? sw_value : flag);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag <= RESET_VALUE;
		else
			flag <= next_flag;
	end

endmodule

// [verif/irq_bank_props.sv]
// port assertions of the interrupt enable and flag bank
`include "irq_bank_consts.vh"
module irq_bank_props
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic timer1_ovf_evt,
	input logic ext_pin_evt,
	input logic [`PIN_FLAG_W-1:0] per_pin_change_flags,
	input logic uart_rx_nonempty,
	input logic uart_tx_empty,
	input logic [7:0] irq_enable_reg1,
	input logic [7:0] flag0_out,
	input logic [7:0] flag1_out,
	input logic periph_irq_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_tmr1_set: assert property (timer1_ovf_evt |=> flag1_out[0]) else $error("t1 set");
	a_ext_set: assert property (ext_pin_evt |=> flag0_out[0]) else $error("ext set");
	a_pin_or: assert property (flag0_out[4] == |per_pin_change_flags) else $error("pin or");
	a_uart_live: assert property (flag1_out[5:4] == {uart_rx_nonempty, uart_tx_empty})
		else $error("uart");
	a_unimpl_zero: assert property ((flag0_out & 8'hCE) == 8'h00) else $error("unimpl");
	a_t0_hold: assert property (flag0_out[5] && !psel |=> flag0_out[5]) else $error("t0");
	a_t1_hold: assert property (flag1_out[0] && !psel |=> flag1_out[0]) else $error("t1");
	a_req_pair: assert property (flag1_out[0] && irq_enable_reg1[0] |=> periph_irq_req)
		else $error("req");
	cover property (periph_irq_req);
	cover property (timer1_ovf_evt && psel);
	cover property (flag0_out[4]);
endmodule
bind peripheral_irq_enable_flags irq_bank_props i_irq_bank_props (.*);

// [verif/irq_periph_model.sv]
// peripheral event source: registered copy of the request strobes, one cycle later
module irq_periph_model
(
	input logic pclk,
	input logic presetn,
	input logic [7:0] fire,
	output logic [7:0] evt
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			evt <= 8'h00;
		else
			evt <= fire;
endmodule

// [verif/peripheral_irq_enable_flags_tb_top.sv]
// self-checking bench of the interrupt enable and flag bank
`include "irq_bank_consts.vh"
module peripheral_irq_enable_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
	logic uart_rx_nonempty = 0, uart_tx_empty = 0, periph_irq_req, timer0_ovf_evt, ext_pin_evt;
	logic timer1_gate_closed_evt, conversion_done_evt, serial_port_evt, bus_collision_evt;
	logic timer2_match_evt, timer1_ovf_evt;
	logic [3:0] pstrb = 4'h1;
	logic [`ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r, lf = 32'h0000_5b64;
	logic [`PIN_FLAG_W-1:0] per_pin_change_flags = '0;
	logic [7:0] irq_enable_reg0 = '0, irq_enable_reg1 = '0, irq_flag_reg3 = '0, irq_flag_reg4 = '0;
	logic [7:0] enable3_out, enable4_out, flag0_out, flag1_out, evt, ev, fire = '0;
	logic [7:0] e3 = '0, e4 = '0, x0 = '0, x1 = '0;
	int n_mismatch = 0, compares = 0;
	assign {timer1_gate_closed_evt, conversion_done_evt, timer0_ovf_evt, ext_pin_evt} = evt[7:4];
	assign {serial_port_evt, bus_collision_evt, timer2_match_evt, timer1_ovf_evt} = evt[3:0];
	peripheral_irq_enable_flags i_peripheral_irq_enable_flags (.*);
	irq_periph_model i_irq_periph_model (.*);
	always #10 pclk = ~pclk;
	function logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function logic rq();
		return |(e3 & irq_flag_reg3 | e4 & irq_flag_reg4 | x0 & irq_enable_reg0 | x1 & irq_enable_reg1);
	endfunction
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task complete_run;
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#40000;
		n_mismatch++;
		complete_run;
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i += 4)
		begin
			apb(1'b0, i[11:0], '0);
			chk("reset", r, '0);
		end
		for (int i = 0; i < 24; i++)
		begin
			lf = nx(lf);
			irq_flag_reg3 <= lf[31:24];
			irq_flag_reg4 <= lf[23:16];
			apb(1'b1, lf[9] ? `OFS_ENABLE4 : `OFS_ENABLE3, lf);
			if (lf[9])
				e4 = lf[7:0];
			else
				e3 = lf[7:0];
			apb(1'b0, lf[9] ? `OFS_ENABLE4 : `OFS_ENABLE3, '0);
			chk("enable", r, lf[7:0]);
			chk("enable_out", lf[9] ? enable4_out : enable3_out, lf[7:0]);
			chk("slverr_mapped", se, 1'b0);
			chk("req", periph_irq_req, rq());
		end
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		chk("slverr_unmapped", se, 1'b1);
		apb(1'b0, `OFS_ENABLE3, '0);
		chk("unmapped", r, e3);
		for (int k = 0; k < 8; k++)
		begin
			lf = nx(lf);
			ev = k ? lf[7:0] : 8'hFF;
			per_pin_change_flags <= k[0] ? lf[31:8] : '0;
			uart_rx_nonempty <= lf[8];
			uart_tx_empty <= lf[9];
			irq_enable_reg0 <= lf[15:8];
			irq_enable_reg1 <= lf[23:16];
			apb(1'b1, `OFS_FLAG0, '0);
			// the event strobe lands on the clearing write edge
			fork
				apb(1'b1, `OFS_FLAG1, '0);
				begin
					@(posedge pclk);
					fire <= ev;
					@(posedge pclk);
					fire <= '0;
				end
			join
			x1 = ev & `FLAG1_WMASK | {2'b00, uart_rx_nonempty, uart_tx_empty, 4'h0};
			x0 = {2'b00, ev[5], |per_pin_change_flags, 3'b000, ev[4]};
			apb(1'b0, `OFS_FLAG1, '0);
			chk("flag1", r, x1);
			apb(1'b0, `OFS_FLAG0, '0);
			chk("flag0", r, x0);
			chk("flag1_out", flag1_out, x1);
			chk("flag0_out", flag0_out, x0);
			chk("req", periph_irq_req, rq());
		end
		complete_run;
	end
endmodule
